// ---- dcec_defines.svh ----
// register offsets, field positions and reset values of the event counter card
`ifndef DCEC_DEFINES_SVH
`define DCEC_DEFINES_SVH

// ==========================================================================
// register byte offsets
`define DCEC_OFF_DIN       8'h00
`define DCEC_OFF_DOUT      8'h04
`define DCEC_OFF_CARD_ID   8'h08
`define DCEC_OFF_CTRL      8'h0c
`define DCEC_OFF_IRQ_STAT  8'h10
`define DCEC_OFF_IRQ_MASK  8'h14
`define DCEC_OFF_CNT_A     8'h18
`define DCEC_OFF_MATCH_A   8'h1c
`define DCEC_OFF_CNT_B     8'h20
`define DCEC_OFF_MATCH_B   8'h24

// ==========================================================================
// control fields, per channel: enable, rising edge, gate used, match irq enable, clear
`define DCEC_CTRL_EN_A     0
`define DCEC_CTRL_RISE_A   1
`define DCEC_CTRL_GATE_A   2
`define DCEC_CTRL_MIE_A    3
`define DCEC_CTRL_CLR_A    4
`define DCEC_CTRL_EN_B     8
`define DCEC_CTRL_RISE_B   9
`define DCEC_CTRL_GATE_B   10
`define DCEC_CTRL_MIE_B    11
`define DCEC_CTRL_CLR_B    12

// status and mask bits
`define DCEC_IRQ_MATCH_A   0
`define DCEC_IRQ_MATCH_B   1
`define DCEC_IRQ_OVF_A     2
`define DCEC_IRQ_OVF_B     3

// ==========================================================================
// reset values and fixed figures
`define DCEC_CTRL_RST      32'h0000_0000
`define DCEC_DOUT_RST      8'h00
`define DCEC_MATCH_RST     32'hffff_ffff
`define DCEC_SRC_A_BIT     0
`define DCEC_SRC_B_BIT     4
`define DCEC_GATE_A_BIT    2
`define DCEC_GATE_B_BIT    6

`endif

// ---- dcec_pkg.sv ----
// types shared by the event counter card design
package dcec_pkg;

   // ==========================================================================
   // per-channel counter configuration
   typedef struct packed {
      logic enable;
      logic rising;
      logic gate_use;
      logic clear;
   } dcec_cfg_s;

   // per-channel event pulses
   typedef struct packed {
      logic match;
      logic overflow;
   } dcec_evt_s;

   // bus slave states
   typedef enum logic [1:0] {
      DCEC_WR_IDLE = 2'b00,
      DCEC_WR_RESP = 2'b01
   } dcec_wr_e;

endpackage : dcec_pkg

// ---- dcec_counter.sv ----
// one 32-bit edge counter with gate, edge select, match and overflow pulses
`include "dcec_defines.svh"

module dcec_counter #(
   parameter int WIDTH = 32
) (
   input  wire logic               clk_sys,
   input  wire logic               nrst,
   input  wire dcec_pkg::dcec_cfg_s cfg,
   input  wire logic               src_sync,
   input  wire logic               gate_sync,
   input  wire logic [WIDTH-1:0]   match_val,
   output logic      [WIDTH-1:0]   count_q,
   output dcec_pkg::dcec_evt_s     evt_q
);

   logic             src_prev_q;
   logic             edge_hit;
   logic             gate_ok;
   logic [WIDTH-1:0] count_d;

   // ==========================================================================
   // edge detection on the already synchronised source
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         src_prev_q <= 1'b0;
      end else begin
         src_prev_q <= src_sync;
      end
   end

   assign edge_hit = cfg.rising ? (src_sync & ~src_prev_q)
                                : (~src_sync & src_prev_q);
   assign gate_ok  = ~cfg.gate_use | gate_sync;
   assign count_d  = count_q + {{(WIDTH-1){1'b0}}, 1'b1};

   // ==========================================================================
   // counting: wraps to zero on overflow and keeps going past a match
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         count_q <= '0;
      end else if (cfg.clear) begin
         count_q <= '0;
      end else if (cfg.enable && gate_ok && edge_hit) begin
         count_q <= count_d;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         evt_q <= '0;
      end else begin
         evt_q.match    <= cfg.enable && gate_ok && edge_hit && !cfg.clear
                           && (count_d == match_val);
         evt_q.overflow <= cfg.enable && gate_ok && edge_hit && !cfg.clear
                           && (count_q == {WIDTH{1'b1}});
      end
   end

endmodule : dcec_counter

// ---- dcec_top.sv ----
// isolated digital i/o card with two event counters behind an axi4-lite slave
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`include "dcec_defines.svh"

module dcec_top #(
   parameter int NUM_IN  = 16,
   parameter int NUM_OUT = 8,
   parameter int CWIDTH  = 32
) (
   input  wire logic                clk_sys,
   input  wire logic                nrst,
   input  wire logic [NUM_IN-1:0]   iso_input,
   output logic      [NUM_OUT-1:0]  iso_output,
   input  wire logic [3:0]          card_id_switch,
   input  wire logic                output_retain_jumper,
   output logic                     irq,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready
);

   // ==========================================================================
   // pin synchronisers
   logic [NUM_IN-1:0] in_meta_q;
   logic [NUM_IN-1:0] in_sync_q;
   logic [3:0]        id_meta_q;
   logic [3:0]        id_sync_q;
   logic              jmp_meta_q;
   logic              jmp_sync_q;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         in_meta_q  <= '0;
         in_sync_q  <= '0;
         id_meta_q  <= '0;
         id_sync_q  <= '0;
      end else begin
         in_meta_q  <= iso_input;
         in_sync_q  <= in_meta_q;
         id_meta_q  <= card_id_switch;
         id_sync_q  <= id_meta_q;
      end
   end

   // no reset here: the jumper must have settled while reset is still held
   always_ff @(posedge clk_sys) begin
      jmp_meta_q <= output_retain_jumper;
      jmp_sync_q <= jmp_meta_q;
   end

   // ==========================================================================
   // registers
   logic [31:0]        ctrl_q;
   logic [3:0]         irq_stat_q;
   logic [3:0]         irq_mask_q;
   logic [CWIDTH-1:0]  match_a_q;
   logic [CWIDTH-1:0]  match_b_q;
   logic [NUM_OUT-1:0] dout_q;
   logic [NUM_OUT-1:0] dout_keep_q;
   logic               dout_keep_vld_q;
   logic               rst_seen_q;
   logic [CWIDTH-1:0]  cnt_a;
   logic [CWIDTH-1:0]  cnt_b;
   dcec_pkg::dcec_evt_s evt_a;
   dcec_pkg::dcec_evt_s evt_b;
   dcec_pkg::dcec_cfg_s cfg_a;
   dcec_pkg::dcec_cfg_s cfg_b;

   // write channel
   logic        aw_got_q;
   logic        w_got_q;
   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        wr_fire;
   dcec_pkg::dcec_wr_e wr_st_q;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   function automatic logic known(input logic [7:0] a);
      logic ok;
      ok = 1'b0;
      case (a)
         `DCEC_OFF_DIN, `DCEC_OFF_DOUT, `DCEC_OFF_CARD_ID, `DCEC_OFF_CTRL,
         `DCEC_OFF_IRQ_STAT, `DCEC_OFF_IRQ_MASK, `DCEC_OFF_CNT_A,
         `DCEC_OFF_MATCH_A, `DCEC_OFF_CNT_B, `DCEC_OFF_MATCH_B: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : known

   assign wr_fire = (wr_st_q == dcec_pkg::DCEC_WR_IDLE) && aw_got_q && w_got_q;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         aw_got_q      <= 1'b0;
         w_got_q       <= 1'b0;
         aw_addr_q     <= '0;
         w_data_q      <= '0;
         w_strb_q      <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
         wr_st_q       <= dcec_pkg::DCEC_WR_IDLE;
      end else begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         case (wr_st_q)
            dcec_pkg::DCEC_WR_IDLE: begin
               if (s_axi_awvalid && !aw_got_q && !s_axi_awready) begin
                  s_axi_awready <= 1'b1;
                  aw_got_q      <= 1'b1;
                  aw_addr_q     <= s_axi_awaddr;
               end
               if (s_axi_wvalid && !w_got_q && !s_axi_wready) begin
                  s_axi_wready <= 1'b1;
                  w_got_q      <= 1'b1;
                  w_data_q     <= s_axi_wdata;
                  w_strb_q     <= s_axi_wstrb;
               end
               if (wr_fire) begin
                  aw_got_q     <= 1'b0;
                  w_got_q      <= 1'b0;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= known(aw_addr_q) ? 2'b00 : 2'b10;
                  wr_st_q      <= dcec_pkg::DCEC_WR_RESP;
               end
            end
            dcec_pkg::DCEC_WR_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  wr_st_q      <= dcec_pkg::DCEC_WR_IDLE;
               end
            end
            default: wr_st_q <= dcec_pkg::DCEC_WR_IDLE;
         endcase
      end
   end

   // ==========================================================================
   // control and match registers; clear bits self-reset after one cycle
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ctrl_q    <= `DCEC_CTRL_RST;
         match_a_q <= `DCEC_MATCH_RST;
         match_b_q <= `DCEC_MATCH_RST;
         irq_mask_q <= '0;
      end else begin
         ctrl_q[`DCEC_CTRL_CLR_A] <= 1'b0;
         ctrl_q[`DCEC_CTRL_CLR_B] <= 1'b0;
         if (wr_fire) begin
            case (aw_addr_q)
               `DCEC_OFF_CTRL:     ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
               `DCEC_OFF_MATCH_A:  match_a_q <= merge(match_a_q, w_data_q, w_strb_q);
               `DCEC_OFF_MATCH_B:  match_b_q <= merge(match_b_q, w_data_q, w_strb_q);
               `DCEC_OFF_IRQ_MASK: begin
                  if (w_strb_q[0]) begin
                     irq_mask_q <= w_data_q[3:0];
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // outputs: retained copy survives reset when the jumper is set
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         dout_q     <= `DCEC_DOUT_RST;
         rst_seen_q <= 1'b0;
      end else begin
         rst_seen_q <= 1'b1;
         if (!rst_seen_q && jmp_sync_q && dout_keep_vld_q) begin
            dout_q <= dout_keep_q;
         end else if (wr_fire && aw_addr_q == `DCEC_OFF_DOUT && w_strb_q[0]) begin
            dout_q <= w_data_q[NUM_OUT-1:0];
         end
      end
   end

   // no async reset so the last output value outlives a card reset
   always_ff @(posedge clk_sys) begin
      if (rst_seen_q) begin
         dout_keep_q     <= dout_q;
         dout_keep_vld_q <= 1'b1;
      end else if (dout_keep_vld_q !== 1'b1) begin
         dout_keep_q     <= `DCEC_DOUT_RST;
         dout_keep_vld_q <= 1'b0;
      end
   end

   // pins follow the output register one cycle later
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         iso_output <= `DCEC_DOUT_RST;
      end else begin
         iso_output <= dout_q;
      end
   end

   // ==========================================================================
   // counter channels
   assign cfg_a = '{enable: ctrl_q[`DCEC_CTRL_EN_A], rising: ctrl_q[`DCEC_CTRL_RISE_A],
                    gate_use: ctrl_q[`DCEC_CTRL_GATE_A], clear: ctrl_q[`DCEC_CTRL_CLR_A]};
   assign cfg_b = '{enable: ctrl_q[`DCEC_CTRL_EN_B], rising: ctrl_q[`DCEC_CTRL_RISE_B],
                    gate_use: ctrl_q[`DCEC_CTRL_GATE_B], clear: ctrl_q[`DCEC_CTRL_CLR_B]};

   dcec_counter #(.WIDTH(CWIDTH)) u_cnt_a (
      .clk_sys   (clk_sys),
      .nrst      (nrst),
      .cfg       (cfg_a),
      .src_sync  (in_sync_q[`DCEC_SRC_A_BIT]),
      .gate_sync (in_sync_q[`DCEC_GATE_A_BIT]),
      .match_val (match_a_q),
      .count_q   (cnt_a),
      .evt_q     (evt_a)
   );

   dcec_counter #(.WIDTH(CWIDTH)) u_cnt_b (
      .clk_sys   (clk_sys),
      .nrst      (nrst),
      .cfg       (cfg_b),
      .src_sync  (in_sync_q[`DCEC_SRC_B_BIT]),
      .gate_sync (in_sync_q[`DCEC_GATE_B_BIT]),
      .match_val (match_b_q),
      .count_q   (cnt_b),
      .evt_q     (evt_b)
   );

   // ==========================================================================
   // interrupt status: set wins over write-one-to-clear
   logic [3:0] evt_vec;
   logic [3:0] w1c;

   assign evt_vec = {evt_b.overflow, evt_a.overflow,
                     evt_b.match & ctrl_q[`DCEC_CTRL_MIE_B],
                     evt_a.match & ctrl_q[`DCEC_CTRL_MIE_A]};
   assign w1c = (wr_fire && aw_addr_q == `DCEC_OFF_IRQ_STAT && w_strb_q[0]) ?
                w_data_q[3:0] : 4'h0;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         irq_stat_q <= '0;
         irq        <= 1'b0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~w1c) | evt_vec;
         irq        <= |(((irq_stat_q & ~w1c) | evt_vec) & irq_mask_q);
      end
   end

   // ==========================================================================
   // read channel: one cycle from address to data
   logic [31:0] rd_val;

   always_comb begin
      rd_val = 32'h0000_0000;
      case (s_axi_araddr)
         `DCEC_OFF_DIN:      rd_val = {{(32-NUM_IN){1'b0}}, in_sync_q};
         `DCEC_OFF_DOUT:     rd_val = {{(32-NUM_OUT){1'b0}}, dout_q};
         `DCEC_OFF_CARD_ID:  rd_val = {28'h0, ~id_sync_q};
         `DCEC_OFF_CTRL:     rd_val = ctrl_q;
         `DCEC_OFF_IRQ_STAT: rd_val = {28'h0, irq_stat_q};
         `DCEC_OFF_IRQ_MASK: rd_val = {28'h0, irq_mask_q};
         `DCEC_OFF_CNT_A:    rd_val = cnt_a;
         `DCEC_OFF_MATCH_A:  rd_val = match_a_q;
         `DCEC_OFF_CNT_B:    rd_val = cnt_b;
         `DCEC_OFF_MATCH_B:  rd_val = match_b_q;
         default:            rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= 2'b00;
      end else begin
         s_axi_arready <= 1'b0;
         if (s_axi_rvalid) begin
            if (s_axi_rready) begin
               s_axi_rvalid <= 1'b0;
            end
         end else if (s_axi_arvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_val;
            s_axi_rresp   <= known(s_axi_araddr) ? 2'b00 : 2'b10;
         end
      end
   end

endmodule : dcec_top

// ---- dcec_top_checker.sv ----
// port checker of the event counter card, bound to the top module
module dcec_top_checker #(
   parameter int NUM_OUT = 8
) (
   input wire logic               clk_sys,
   input wire logic               nrst,
   input wire logic [NUM_OUT-1:0] iso_output,
   input wire logic               irq,
   input wire logic               s_axi_awvalid,
   input wire logic               s_axi_awready,
   input wire logic               s_axi_wvalid,
   input wire logic               s_axi_wready,
   input wire logic               s_axi_bvalid,
   input wire logic               s_axi_bready,
   input wire logic               s_axi_arvalid,
   input wire logic               s_axi_arready,
   input wire logic [31:0]        s_axi_rdata,
   input wire logic [1:0]         s_axi_rresp,
   input wire logic               s_axi_rvalid,
   input wire logic               s_axi_rready
);
   // ==========================================================================
   // helpers
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   logic [2:0] up_q;
   logic       wr_take;
   assign wr_take = s_axi_wvalid && s_axi_wready;
   // outputs may reload a retained value just after reset, so wait before judging them
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) up_q <= 3'h0;
      else if (up_q != 3'h7) up_q <= up_q + 3'h1;
   end

   // ==========================================================================
   // assertions
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before bready");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
   AST_AW_TAKE: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
      |-> ##[0:3] s_axi_awready) else $error("write address not taken");
   AST_B_AFTER: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
      else $error("no write response");
   AST_R_AFTER: assert property (s_axi_arvalid && s_axi_arready |-> ##[0:2] s_axi_rvalid)
      else $error("no read response");
   AST_AR_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
      else $error("arready longer than one cycle");
   AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
      else $error("refused read returns data");
   AST_OUT_CAUSE: assert property (up_q == 3'h7 && !$stable(iso_output) |->
      $past(wr_take) || $past(wr_take, 2) || $past(wr_take, 3)) else $error("outputs moved alone");
   AST_IRQ_FALL: assert property ($fell(irq) |->
      $past(wr_take) || $past(wr_take, 2) || $past(wr_take, 3)) else $error("irq dropped alone");
endmodule : dcec_top_checker

bind dcec_top dcec_top_checker #(.NUM_OUT(NUM_OUT)) u_chk (
   .clk_sys(clk_sys), .nrst(nrst), .iso_output(iso_output), .irq(irq),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ---- dcec_field_model.sv ----
// field side model: drives the isolated inputs and makes count pulses
module dcec_field_model (
   input  wire logic        clk_sys,
   input  wire logic [15:0] level,
   input  wire logic        go,
   input  wire logic [3:0]  pin,
   input  wire logic [7:0]  n,
   output logic             busy,
   output logic [15:0]      pins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] left_q = 8'h00;
   logic [2:0] ph_q   = 3'h0;
   logic       hi_q   = 1'b0;
   // 8 cycles high, 8 low: slow next to the synchroniser, so no edge is lost
   always @(posedge clk_sys) begin
      if (go) begin
         left_q <= n;
         ph_q   <= 3'h0;
      end else if (left_q != 8'h00) begin
         ph_q <= ph_q + 3'h1;
         if (ph_q == 3'h7) begin
            hi_q <= !hi_q;
            if (hi_q) left_q <= left_q - 8'h01;
         end
      end
   end
   assign busy = (left_q != 8'h00) || go;
   assign pins = level ^ (16'(hi_q) << pin);
endmodule : dcec_field_model

// ---- testbench.sv ----
// self-checking bench of the event counter card
`include "dcec_defines.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [15:0] lvl;
      logic [3:0]  sw;
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic [31:0] exp;
      logic [1:0]  resp;
   } dcec_row_s;
   logic clk_sys = 1'b0, nrst = 1'b0, jmp = 1'b0, irq, go = 1'b0, busy;
   logic [15:0] level = 16'h0, iso_input;
   logic [7:0]  iso_output, n = 8'h0;
   logic [3:0]  sw = 4'hf, pin = 4'h0;
   logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r, b;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int fail_count = 0, samples_checked = 0;
   dcec_row_s rows [6] = '{
      '{16'h1234, 4'hf, 1'b0, `DCEC_OFF_DIN, 32'h0, 32'h1234, 2'b00},
      '{16'h0, 4'hf, 1'b1, `DCEC_OFF_DOUT, 32'h1a5, 32'ha5, 2'b00},
      '{16'h0, 4'h0, 1'b0, `DCEC_OFF_CARD_ID, 32'h0, 32'hf, 2'b00},
      '{16'h0, 4'h5, 1'b0, `DCEC_OFF_CARD_ID, 32'h0, 32'ha, 2'b00},
      '{16'h0, 4'hf, 1'b0, `DCEC_OFF_MATCH_A, 32'h0, 32'hffff_ffff, 2'b00},
      '{16'h0, 4'hf, 1'b1, 8'h40, 32'h5, 32'h0, 2'b10}};

   dcec_top dut (.clk_sys(clk_sys), .nrst(nrst), .iso_input(iso_input),
      .iso_output(iso_output), .card_id_switch(sw), .output_retain_jumper(jmp), .irq(irq),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   dcec_field_model u_field (.clk_sys(clk_sys), .level(level), .go(go), .pin(pin), .n(n),
      .busy(busy), .pins(iso_input));

   always #2 clk_sys = !clk_sys;

   // ==========================================================================
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      logic aw, w;
      aw = 1'b1;
      w  = 1'b1;
      @(posedge clk_sys);
      s_axi_awaddr <= a; s_axi_awvalid <= 1'b1;
      s_axi_wdata <= v; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      while (aw || w) begin
         @(posedge clk_sys);
         if (aw && s_axi_awready) begin aw = 1'b0; s_axi_awvalid <= 1'b0; end
         if (w && s_axi_wready) begin w = 1'b0; s_axi_wvalid <= 1'b0; end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
      b = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axw
   task automatic axr(input logic [7:0] a);
      @(posedge clk_sys);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge clk_sys);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axr
   task automatic pulse(input logic [3:0] p, input logic [7:0] k);
      @(posedge clk_sys);
      go <= 1'b1; pin <= p; n <= k;
      @(posedge clk_sys);
      go <= 1'b0;
      while (busy) @(posedge clk_sys);
      repeat (6) @(posedge clk_sys);
   endtask : pulse
   task automatic reset_cycle();
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b0;
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (4) @(posedge clk_sys);
   endtask : reset_cycle
   task automatic end_of_test();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test

   // ==========================================================================
   // watchdog: the whole sequence needs well under 10 us
   initial begin
      #100us;
      fail_count++;
      end_of_test();
   end

   initial begin
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk(32'(iso_output), 32'h0);
      foreach (rows[i]) begin
         level <= rows[i].lvl;
         sw <= rows[i].sw;
         repeat (4) @(posedge clk_sys);
         if (rows[i].wr) begin
            axw(rows[i].addr, rows[i].wdata);
            chk(32'(b), 32'(rows[i].resp));
         end
         axr(rows[i].addr);
         chk(d, rows[i].exp);
         chk(32'(r), 32'(rows[i].resp));
      end
      // counter a: rising then falling edges
      axw(`DCEC_OFF_CTRL, 32'h3);
      pulse(4'd0, 8'd5);
      axr(`DCEC_OFF_CNT_A); chk(d, 32'd5);
      axw(`DCEC_OFF_CTRL, 32'h1);
      pulse(4'd0, 8'd3);
      axr(`DCEC_OFF_CNT_A); chk(d, 32'd8);
      // counter b: gate low holds, gate high counts
      axw(`DCEC_OFF_CTRL, 32'h701);
      pulse(4'd4, 8'd3);
      axr(`DCEC_OFF_CNT_B); chk(d, 32'd0);
      level <= 16'h0040;
      pulse(4'd4, 8'd2);
      axr(`DCEC_OFF_CNT_B); chk(d, 32'd2);
      // match interrupt on counter a, masked and cleared
      axw(`DCEC_OFF_MATCH_A, 32'd10);
      axw(`DCEC_OFF_IRQ_MASK, 32'h1);
      axw(`DCEC_OFF_CTRL, 32'h70b);
      pulse(4'd0, 8'd1);
      chk(32'(irq), 32'h0);
      pulse(4'd0, 8'd1);
      chk(32'(irq), 32'h1);
      pulse(4'd0, 8'd1);
      axr(`DCEC_OFF_CNT_A); chk(d, 32'd11);
      axw(`DCEC_OFF_IRQ_MASK, 32'h0);
      repeat (3) @(posedge clk_sys);
      chk(32'(irq), 32'h0);
      axw(`DCEC_OFF_IRQ_MASK, 32'h1);
      repeat (3) @(posedge clk_sys);
      chk(32'(irq), 32'h1);
      axw(`DCEC_OFF_IRQ_STAT, 32'h1);
      repeat (3) @(posedge clk_sys);
      chk(32'(irq), 32'h0);
      // the self-clearing clear bit restarts counter a
      axw(`DCEC_OFF_CTRL, 32'h71b);
      axr(`DCEC_OFF_CNT_A); chk(d, 32'd0);
      // outputs across reset with and without the retain jumper
      axw(`DCEC_OFF_DOUT, 32'h3c);
      jmp <= 1'b1;
      reset_cycle();
      chk(32'(iso_output), 32'h3c);
      jmp <= 1'b0;
      reset_cycle();
      chk(32'(iso_output), 32'h0);
      end_of_test();
   end
endmodule : testbench
